// ---- core/lbcs_pkg.sv ----
// Functional notes
// - Writing one to bit 7 of the output enable control register resets every register to default and self-clears.
// - With the overvoltage action bit clear a backlight overvoltage only flags; set, it shuts the backlight down.
// - Bit 4 enables backlight sink 1 alone when set and resets to zero.
// - Bit 3 enables both sinks regardless of bit 4; clear, sink 2 is off and sink 1 follows bit 4.
// - Bit 2 selects torch (zero, default) or flash (one) mode for the flash LED output.
// - Bit 1 enables the flash output and bit 0 the backlight output; both reset disabled.
// - The fault flag register at 0x0B is read-only, resets to 0x00, and reports eight faults from bit 7 down.
// - Bit 7 of the bias configuration register enables wake-up mode, default off.
// - Bit 6 selects the positive bias ramp: 800 us when zero (default), 500 us when one.
// - Bit 5 enables automatic bias sequencing, reset disabled.
// - Bit 4 selects active discharge of the positive rail, default on.
// - Bit 3 selects active discharge of the negative rail, default on.
// - Bits 2 and 1 enable the positive and negative rails, reset disabled.
// - Bit 0 clear enables rails only by register bits; set, only by the enable pins.
// - The bias configuration register sits at 0x0C and resets to 0x18.
package lbcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] LBCS_ADDR_ENABLE = 8'h0a;
  localparam logic [7:0] LBCS_ADDR_FLAGS  = 8'h0b;
  localparam logic [7:0] LBCS_ADDR_BIAS   = 8'h0c;

  // Reset values
  localparam logic [7:0] LBCS_RST_ENABLE = 8'h00;
  localparam logic [7:0] LBCS_RST_FLAGS  = 8'h00;
  localparam logic [7:0] LBCS_RST_BIAS   = 8'h18;

  // Field positions, output enable control
  localparam int LBCS_EN_SWRST  = 7;
  localparam int LBCS_EN_OVPACT = 5;
  localparam int LBCS_EN_SINK1  = 4;
  localparam int LBCS_EN_BOTH   = 3;
  localparam int LBCS_EN_FMODE  = 2;
  localparam int LBCS_EN_FLASH  = 1;
  localparam int LBCS_EN_BL     = 0;

  // Field positions, display bias configuration
  localparam int LBCS_BI_WAKE   = 7;
  localparam int LBCS_BI_RAMP   = 6;
  localparam int LBCS_BI_AUTO   = 5;
  localparam int LBCS_BI_PDIS   = 4;
  localparam int LBCS_BI_NDIS   = 3;
  localparam int LBCS_BI_PEN    = 2;
  localparam int LBCS_BI_NEN    = 1;
  localparam int LBCS_BI_PINSEL = 0;

  // Ramp times and their cycle counts at 100 MHz
  localparam int LBCS_CLK_MHZ       = 100;
  localparam int LBCS_RAMP_SLOW_US  = 800;
  localparam int LBCS_RAMP_FAST_US  = 500;
  localparam int LBCS_RAMP_SLOW_CYC = LBCS_RAMP_SLOW_US * LBCS_CLK_MHZ;
  localparam int LBCS_RAMP_FAST_CYC = LBCS_RAMP_FAST_US * LBCS_CLK_MHZ;

  // Fault event inputs, bit 7 down to bit 0 of the flag register
  typedef struct packed {
    logic backlight_overvolt_flag;
    logic flash_overvolt_flag;
    logic flash_out_short_flag;
    logic input_voltage_monitor_flag;
    logic transmit_interrupt_flag;
    logic flash_led_short_flag;
    logic flash_timeout_flag;
    logic thermal_shutdown_flag;
  } lbcs_faults_t;

  // Power stage controls
  typedef struct packed {
    logic backlight_on;
    logic sink_one_on;
    logic sink_two_on;
    logic flash_on;
    logic flash_mode;
    logic wakeup_mode;
    logic auto_sequence;
    logic pos_bias_on;
    logic neg_bias_on;
    logic pos_bias_discharge;
    logic neg_bias_discharge;
    logic pos_bias_ramping;
  } lbcs_ctrl_t;

endpackage : lbcs_pkg

// ---- core/lbcs_regs.sv ----
`timescale 1ns/1ns
module lbcs_regs #(
  parameter int RAMP_SLOW_CYC = lbcs_pkg::LBCS_RAMP_SLOW_CYC,
  parameter int RAMP_FAST_CYC = lbcs_pkg::LBCS_RAMP_FAST_CYC
) (
  // Clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // Register port from the serial front end
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  // Fault events and enable pins
  input  wire lbcs_pkg::lbcs_faults_t fault_events,
  input  wire logic                   pos_bias_enable_pin,
  input  wire logic                   neg_bias_enable_pin,
  // Power stage controls
  output lbcs_pkg::lbcs_ctrl_t        ctrl
);
  import lbcs_pkg::*;

  logic [7:0]   output_enable_control;
  logic [7:0]   display_bias_config;
  lbcs_faults_t fault_flag_status;
  logic [7:0]   next_output_enable_control;
  logic [7:0]   next_display_bias_config;
  lbcs_faults_t next_fault_flag_status;
  logic [7:0]   next_reg_rdata;
  logic         next_reg_rvalid;
  lbcs_ctrl_t   next_ctrl;
  logic         bl_tripped;
  logic         next_bl_tripped;
  logic [1:0]   pin_pos_sync;
  logic [1:0]   pin_neg_sync;
  logic [16:0]  ramp_cnt;
  logic [16:0]  next_ramp_cnt;
  logic         pos_on_q;
  logic         pos_now;
  logic         neg_now;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_pos_sync <= 2'h0;
      pin_neg_sync <= 2'h0;
    end else if (clk_en) begin
      pin_pos_sync <= {pin_pos_sync[0], pos_bias_enable_pin};
      pin_neg_sync <= {pin_neg_sync[0], neg_bias_enable_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    next_output_enable_control = output_enable_control;
    next_display_bias_config   = display_bias_config;
    // flags follow fault events, never bus data; they clear when the events drop or on a soft reset write
    next_fault_flag_status     = fault_events;
    next_bl_tripped            = bl_tripped;
    next_reg_rvalid            = reg_rd;
    next_reg_rdata             = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        LBCS_ADDR_ENABLE: next_reg_rdata = output_enable_control;
        LBCS_ADDR_FLAGS:  next_reg_rdata = fault_flag_status;
        LBCS_ADDR_BIAS:   next_reg_rdata = display_bias_config;
        default:          next_reg_rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      if (reg_addr == LBCS_ADDR_ENABLE) begin
        next_output_enable_control = reg_wdata;
        // Re-enabling the backlight re-arms after a trip
        if (reg_wdata[LBCS_EN_BL])
          next_bl_tripped = 1'b0;
      end
      // bias configuration at its own address
      if (reg_addr == LBCS_ADDR_BIAS)
        next_display_bias_config = reg_wdata;
    end
    // overvoltage shuts down only in action mode
    if (fault_events.backlight_overvolt_flag && output_enable_control[LBCS_EN_OVPACT])
      next_bl_tripped = 1'b1;
    // soft reset restores defaults, bit self-clears
    if (reg_wr && reg_addr == LBCS_ADDR_ENABLE && reg_wdata[LBCS_EN_SWRST]) begin
      next_output_enable_control = LBCS_RST_ENABLE;
      next_display_bias_config   = LBCS_RST_BIAS;
      next_fault_flag_status     = LBCS_RST_FLAGS;
      next_bl_tripped            = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs from the registers
  always_comb begin
    // pins or register bits, never both
    pos_now = display_bias_config[LBCS_BI_PINSEL] ? pin_pos_sync[1] : display_bias_config[LBCS_BI_PEN];
    neg_now = display_bias_config[LBCS_BI_PINSEL] ? pin_neg_sync[1] : display_bias_config[LBCS_BI_NEN];
    // ramp length from the select bit
    next_ramp_cnt = ramp_cnt;
    if (pos_now && !pos_on_q)
      next_ramp_cnt = display_bias_config[LBCS_BI_RAMP] ? 17'(RAMP_FAST_CYC) : 17'(RAMP_SLOW_CYC);
    else if (!pos_now)
      next_ramp_cnt = 17'h0;
    else if (ramp_cnt != 17'h0)
      next_ramp_cnt = ramp_cnt - 17'h1;
    // output enables; a trip holds the backlight off
    next_ctrl.backlight_on       = output_enable_control[LBCS_EN_BL] && !bl_tripped;
    next_ctrl.flash_on           = output_enable_control[LBCS_EN_FLASH];
    // torch when clear, flash when set
    next_ctrl.flash_mode         = output_enable_control[LBCS_EN_FMODE];
    // both-sinks bit overrides the single-sink bit
    next_ctrl.sink_two_on        = output_enable_control[LBCS_EN_BOTH];
    next_ctrl.sink_one_on        = output_enable_control[LBCS_EN_BOTH] || output_enable_control[LBCS_EN_SINK1];
    next_ctrl.wakeup_mode        = display_bias_config[LBCS_BI_WAKE];
    next_ctrl.auto_sequence      = display_bias_config[LBCS_BI_AUTO];
    next_ctrl.pos_bias_on        = pos_now;
    next_ctrl.neg_bias_on        = neg_now;
    next_ctrl.pos_bias_discharge = display_bias_config[LBCS_BI_PDIS];
    next_ctrl.neg_bias_discharge = display_bias_config[LBCS_BI_NDIS];
    next_ctrl.pos_bias_ramping   = pos_now && (next_ramp_cnt != 17'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      output_enable_control <= LBCS_RST_ENABLE;
      display_bias_config   <= LBCS_RST_BIAS;
      fault_flag_status     <= LBCS_RST_FLAGS;
      bl_tripped            <= 1'b0;
      reg_rdata             <= 8'h00;
      reg_rvalid            <= 1'b0;
      ctrl                  <= '0;
      ramp_cnt              <= 17'h0;
      pos_on_q              <= 1'b0;
    end else if (clk_en) begin
      // Soft reset bit is never stored, so it reads back zero
      output_enable_control <= next_output_enable_control & ~(8'h01 << LBCS_EN_SWRST);
      display_bias_config   <= next_display_bias_config;
      fault_flag_status     <= next_fault_flag_status;
      bl_tripped            <= next_bl_tripped;
      reg_rdata             <= next_reg_rdata;
      reg_rvalid            <= next_reg_rvalid;
      ctrl                  <= next_ctrl;
      ramp_cnt              <= next_ramp_cnt;
      pos_on_q              <= pos_now;
    end
  end

endmodule : lbcs_regs

// ---- test/lbcs_regs_props.sv ----
`timescale 1ns/1ns
module lbcs_regs_props #(
  parameter int RAMP_SLOW_CYC = 8,
  parameter int RAMP_FAST_CYC = 5
) (
  // Watched ports, grouped by type
  input wire logic                   sys_clk, sys_rst, clk_en, reg_wr, reg_rd, reg_rvalid,
  input wire logic [7:0]             reg_addr, reg_wdata, reg_rdata,
  input wire lbcs_pkg::lbcs_faults_t fault_events,
  input wire lbcs_pkg::lbcs_ctrl_t   ctrl
);
  import lbcs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Decoded writes
  logic wa, wb, wc;
  assign wa = reg_wr && clk_en && reg_addr == 8'h0a;
  assign wb = reg_wr && clk_en && reg_addr == 8'h0b;
  assign wc = reg_wr && clk_en && reg_addr == 8'h0c;
  ////////////////////////////////////////////////////////////////////////////
  // answer one cycle on
  property p_rv; $past(clk_en) && !$past(sys_rst) |-> reg_rvalid == $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("rvalid out of step");
  property p_idle; $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  property p_flg; reg_rd && clk_en && reg_addr == 8'h0b && $stable(fault_events) && !$past(sys_rst)
    |=> reg_rdata == $past(fault_events); endproperty
  a_flg: assert property (p_flg) else $error("flag read wrong");
  property p_snk; ctrl.sink_two_on |-> ctrl.sink_one_on; endproperty
  a_snk: assert property (p_snk) else $error("sink two alone");
  property p_en; wa && !reg_wdata[7] ##1 !wa |=> ctrl.flash_on == $past(reg_wdata[1], 2)
    && ctrl.flash_mode == $past(reg_wdata[2], 2) && ctrl.sink_two_on == $past(reg_wdata[3], 2); endproperty
  a_en: assert property (p_en) else $error("enable fields wrong");
  property p_bi; wc && reg_wdata[5:0] == 6'h06 ##1 !wc |=> ctrl.wakeup_mode == $past(reg_wdata[7], 2)
    && !ctrl.pos_bias_discharge && !ctrl.neg_bias_discharge && ctrl.pos_bias_on && ctrl.neg_bias_on; endproperty
  a_bi: assert property (p_bi) else $error("bias fields wrong");
  property p_sr; wa && reg_wdata[7] ##1 !wa && !wc |=> !ctrl.flash_on && !ctrl.sink_one_on
    && ctrl.pos_bias_discharge && ctrl.neg_bias_discharge; endproperty
  a_sr: assert property (p_sr) else $error("soft reset missed");
  property p_ro; wb ##1 !wa && !wc |=> $stable({ctrl.flash_on, ctrl.flash_mode, ctrl.wakeup_mode}); endproperty
  a_ro: assert property (p_ro) else $error("flag write took");
  c_flg: cover property (reg_rd && reg_addr == 8'h0b && reg_rdata == 8'h00);
  c_sr: cover property (wa && reg_wdata[7]);
  c_pin: cover property (ctrl.pos_bias_on && !ctrl.neg_bias_on);
endmodule : lbcs_regs_props
bind lbcs_regs lbcs_regs_props #(.RAMP_SLOW_CYC(RAMP_SLOW_CYC), .RAMP_FAST_CYC(RAMP_FAST_CYC)) i_lbcs_regs_props (
  .sys_clk, .sys_rst, .clk_en, .reg_wr, .reg_rd, .reg_rvalid, .reg_addr, .reg_wdata, .reg_rdata, .fault_events, .ctrl);

// ---- test/lbcs_host.sv ----
`timescale 1ns/1ns
module lbcs_host (
  // Clock
  input wire logic        sys_clk,
  // Register port toward the block
  output logic            reg_wr, reg_rd,
  output logic [7:0]      reg_addr, reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid
);
  // Idle bus at time zero
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  // One-cycle write; data scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask : wr
  // Read answer stands one cycle, taken at that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge sys_clk);
    {v, d} = {reg_rvalid, reg_rdata};
  endtask : rd
endmodule : lbcs_host

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("wrong value %s exp %h seen %h", n, e, s); end end
module tb_top;
  import lbcs_pkg::*;
  logic         sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, pin_pos = 1'b0, pin_neg = 1'b0, v;
  logic         reg_wr, reg_rd, reg_rvalid;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, d;
  lbcs_faults_t faults = '0;
  lbcs_ctrl_t   ctrl;
  int           bad_count = 0, comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  lbcs_host i_lbcs_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  // Short ramps keep the run brief
  lbcs_regs #(.RAMP_SLOW_CYC(8), .RAMP_FAST_CYC(5)) i_lbcs_regs (.sys_clk, .sys_rst, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .fault_events(faults), .pos_bias_enable_pin(pin_pos),
    .neg_bias_enable_pin(pin_neg), .ctrl);
  ////////////////////////////////////////////////////////////////////////////
  // Write, then let the controls settle
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    i_lbcs_host.wr(a, x);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : wr
  // Read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_lbcs_host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask : rc
  // Drive events or pins, wait past the sync flops
  task automatic ev(input logic [7:0] f, input logic [1:0] p);
    @(posedge sys_clk);
    {faults, pin_pos, pin_neg} <= {f, p};
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : ev
  task automatic t_main;
    rc(8'h0a, 8'h00);
    rc(8'h0c, 8'h18);
    rc(8'h3c, 8'h00);
    `CHK("disch", 2'b11, {ctrl.pos_bias_discharge, ctrl.neg_bias_discharge})
    wr(8'h0a, 8'h5b);
    rc(8'h0a, 8'h5b);
    `CHK("all on", 4'hf, {ctrl.sink_one_on, ctrl.sink_two_on, ctrl.flash_on, ctrl.backlight_on})
    wr(8'h0a, 8'h14);
    `CHK("sink1 flash", 5'h14, {ctrl.sink_one_on, ctrl.sink_two_on, ctrl.flash_mode, ctrl.flash_on, ctrl.backlight_on})
    $display("test enable done");
    ev(8'ha5, 2'b00);
    wr(8'h0b, 8'hff);
    rc(8'h0b, 8'ha5);
    wr(8'h0a, 8'h21);
    ev(8'h80, 2'b00);
    `CHK("bl trip", 1'b0, ctrl.backlight_on)
    ev(8'h00, 2'b00);
    wr(8'h0a, 8'h01);
    ev(8'h80, 2'b00);
    `CHK("bl flag only", 1'b1, ctrl.backlight_on)
    rc(8'h0b, 8'h80);
    $display("test faults done");
    wr(8'h0c, 8'hc6);
    `CHK("ramping", 1'b1, ctrl.pos_bias_ramping)
    rc(8'h0c, 8'hc6);
    `CHK("bias a", 6'h23, {ctrl.wakeup_mode, ctrl.auto_sequence, ctrl.pos_bias_discharge, ctrl.neg_bias_discharge,
      ctrl.pos_bias_on, ctrl.neg_bias_on})
    // Short fast ramp has run out by now
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("ramp over", 1'b0, ctrl.pos_bias_ramping)
    wr(8'h0c, 8'h38);
    `CHK("bias b", 4'he, {ctrl.auto_sequence, ctrl.pos_bias_discharge, ctrl.neg_bias_discharge, ctrl.pos_bias_on})
    wr(8'h0c, 8'h07);
    `CHK("pins off", 2'b00, {ctrl.pos_bias_on, ctrl.neg_bias_on})
    ev(8'h00, 2'b10);
    `CHK("pins on", 2'b10, {ctrl.pos_bias_on, ctrl.neg_bias_on})
    // Clock enable low: a write must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h0c, 8'h00);
    `CHK("frozen ctrl", 1'b1, ctrl.pos_bias_on)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rc(8'h0c, 8'h07);
    wr(8'h0a, 8'h80);
    rc(8'h0a, 8'h00);
    rc(8'h0c, 8'h18);
    $display("test bias done");
  endtask : t_main
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Reset for ten cycles, then run
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_main();
    end_of_test();
  end
endmodule : tb_top
